// File: verif/pfc_stage_model.sv
// Boost stage stand-in: zero-current ringing and ready pull-up
`timescale 1ns/1ps
`default_nettype none
module pfc_stage_model (
    input  wire logic        clock_i,
    input  wire logic        gate_i,
    input  wire logic [15:0] zc_delay_i,
    input  wire logic        ready_oe_i,
    output var  logic        zcs_high_o,
    output var  logic        zcs_low_o,
    output wire logic        ready_pin_o
);
    int off_cnt = 0;
    // External pull-up wins whenever the drain lets go
    assign ready_pin_o = ready_oe_i ? 1'b0 : 1'b1;
    // One ring per off-period; delay 0 is a dead winding, only restart helps
    always @(posedge clock_i) begin
        off_cnt <= gate_i ? 0 : off_cnt + 1;
        if (zc_delay_i != 16'h0000 && !gate_i && off_cnt >= int'(zc_delay_i)
            && off_cnt < int'(zc_delay_i) + 4) begin
            zcs_high_o <= 1'b1;
            zcs_low_o <= 1'b0;
        end else begin
            zcs_high_o <= 1'b0;
            zcs_low_o <= 1'b1;
        end
    end
endmodule : pfc_stage_model
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the gate sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        start = 1'b0, below_stop = 1'b0, below_5v = 1'b1, above_2v = 1'b0;
    logic        fb_hi = 1'b0, fb_lo = 1'b1, ovp = 1'b0, ovp_rel = 1'b1;
    logic        comp_min = 1'b0, rated = 1'b0;
    logic [7:0]  comp = 8'h14;
    logic [15:0] zc_delay = 16'h0190;
    logic        zcs_high, zcs_low, gate, rdy_out, rdy_oe, ext_loop, running, rdy_pin;
    logic [3:0]  ref_step;
    int          n_mismatch = 0;
    int          compares = 0;
    int          n;

    always #5 clock = ~clock;

    crm_pfc_switch_sequencer #(
        .SOFT_CYCLES(24'h0000a0),
        .HANDOVER_CYCLES(24'h000014)
    ) u_crm_pfc_switch_sequencer (
        .clock_i(clock), .resetn_i(resetn), .vcc_above_start_i(start),
        .vcc_below_stop_i(below_stop), .vcc_below_5v_i(below_5v),
        .vcc_above_2v_i(above_2v), .fb_above_ready_i(fb_hi),
        .fb_below_release_i(fb_lo), .fb_above_ovp_i(ovp),
        .fb_below_ovp_release_i(ovp_rel), .zcs_above_high_i(zcs_high),
        .zcs_below_low_i(zcs_low), .comp_below_min_i(comp_min),
        .output_at_rated_i(rated), .comp_level_i(comp), .gate_o(gate),
        .ready_out_o(rdy_out), .ready_oe_o(rdy_oe), .reference_step_o(ref_step),
        .external_loop_o(ext_loop), .running_o(running)
    );

    pfc_stage_model u_pfc_stage_model (
        .clock_i(clock), .gate_i(gate), .zc_delay_i(zc_delay),
        .ready_oe_i(rdy_oe), .zcs_high_o(zcs_high), .zcs_low_o(zcs_low),
        .ready_pin_o(rdy_pin)
    );

    task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_span(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_span

    task automatic ticks(input int k);
        repeat (k) @(negedge clock);
    endtask : ticks

    // Capped so a stuck gate cannot hang the run
    task automatic gate_wait(input logic lvl, input int cap, output int k);
        k = 0;
        while (gate !== lvl && k < cap) begin
            @(negedge clock);
            k++;
        end
    endtask : gate_wait

    task automatic t_power_up;
        ticks(2);
        chk_val("oe floating", 8'h00, {7'h00, rdy_oe});
        chk_val("ref idle", 8'h00, {4'h0, ref_step});
        @(posedge clock) begin
            above_2v <= 1'b1;
            below_5v <= 1'b0;
            fb_hi <= 1'b1;
            fb_lo <= 1'b0;
        end
        ticks(5);
        chk_val("oe before start", 8'h01, {7'h00, rdy_oe});
        chk_val("running early", 8'h00, {7'h00, running});
        @(posedge clock) start <= 1'b1;
        ticks(4);
        chk_val("running", 8'h01, {7'h00, running});
        chk_val("oe ready", 8'h00, {7'h00, rdy_oe});
        chk_val("pin ready", 8'h01, {6'h00, rdy_out, rdy_pin});
        chk_val("ref stepping", 8'h00, {4'h0, ref_step});
        ticks(50);
        chk_val("ref mid", 8'h05, {4'h0, ref_step});
        ticks(150);
        chk_val("ref full", 8'h0f, {4'h0, ref_step});
        chk_val("ext before rated", 8'h00, {7'h00, ext_loop});
        @(posedge clock) rated <= 1'b1;
        ticks(19);
        chk_val("ext early", 8'h00, {7'h00, ext_loop});
        ticks(4);
        chk_val("ext after", 8'h01, {7'h00, ext_loop});
    endtask : t_power_up

    task automatic t_switching;
        // Start from a low gate so the first on-time is measured whole
        gate_wait(1'b0, 300, n);
        gate_wait(1'b1, 16000, n);
        gate_wait(1'b0, 300, n);
        chk_span("on time 20", 20, 22, n);
        @(posedge clock) comp <= 8'h40;
        gate_wait(1'b1, 1000, n);
        chk_span("off time", 403, 408, n);
        gate_wait(1'b0, 300, n);
        chk_span("on time 64", 64, 66, n);
        // Ring lands inside the blanking window, so only restart may fire
        @(posedge clock) comp <= 8'h14;
        gate_wait(1'b1, 1000, n);
        @(posedge clock) zc_delay <= 16'h0050;
        gate_wait(1'b0, 300, n);
        gate_wait(1'b1, 16000, n);
        chk_span("restart gap", 14990, 15010, n);
        @(posedge clock) zc_delay <= 16'h0190;
        gate_wait(1'b0, 300, n);
    endtask : t_switching

    task automatic t_inhibit;
        @(posedge clock) comp_min <= 1'b1;
        gate_wait(1'b1, 2000, n);
        chk_span("low comp", 2000, 2000, n);
        @(posedge clock) comp_min <= 1'b0;
        gate_wait(1'b1, 16000, n);
        gate_wait(1'b0, 300, n);
        @(posedge clock) begin
            ovp <= 1'b1;
            ovp_rel <= 1'b0;
        end
        ticks(2);
        @(posedge clock) ovp <= 1'b0;
        gate_wait(1'b1, 2000, n);
        chk_span("ovp band", 2000, 2000, n);
        @(posedge clock) ovp_rel <= 1'b1;
        gate_wait(1'b1, 16000, n);
        chk_span("ovp resume", 0, 15010, n);
    endtask : t_inhibit

    task automatic t_ready_and_stop;
        @(posedge clock) fb_hi <= 1'b0;
        ticks(4);
        chk_val("oe band", 8'h00, {7'h00, rdy_oe});
        @(posedge clock) fb_lo <= 1'b1;
        ticks(4);
        chk_val("oe release", 8'h01, {7'h00, rdy_oe});
        @(posedge clock) fb_lo <= 1'b0;
        ticks(4);
        chk_val("oe held low", 8'h01, {7'h00, rdy_oe});
        @(posedge clock) fb_hi <= 1'b1;
        @(posedge clock) start <= 1'b0;
        ticks(4);
        chk_val("oe again", 8'h00, {7'h00, rdy_oe});
        chk_val("run kept", 8'h01, {7'h00, running});
        @(posedge clock) below_stop <= 1'b1;
        ticks(4);
        chk_val("run stopped", 8'h00, {7'h00, running});
        gate_wait(1'b1, 2000, n);
        chk_span("gate stopped", 2000, 2000, n);
        chk_val("oe after stop", 8'h00, {7'h00, rdy_oe});
        @(posedge clock) below_5v <= 1'b1;
        ticks(4);
        chk_val("oe below 5v", 8'h01, {7'h00, rdy_oe});
        @(posedge clock) above_2v <= 1'b0;
        ticks(4);
        chk_val("oe below 2v", 8'h00, {7'h00, rdy_oe});
    endtask : t_ready_and_stop

    task automatic give_verdict;
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        t_power_up();
        t_switching();
        t_inhibit();
        t_ready_and_stop();
        give_verdict();
    end

    // Whole sequence needs about 50k cycles
    initial begin
        repeat (95000) @(posedge clock);
        n_mismatch++;
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire

// File: verilog/crm_pfc_switch_sequencer.sv
// Gate sequencer, soft-start, handover and ready flag
`timescale 1ns/1ps
`default_nettype none
`include "pfc_seq_cfg.svh"
// Functional notes
// - Ready rises above 2.24 V, falls below 2.051 V
// - No ready before supply first reaches start
// - Ready held after switching stops while above
// - Ready forced low when supply below 5 V
// - Ready is open drain, floats below 2 V
// - Zero-current comparator: 1.5 V rise, 1.4 V fall
// - On-period starts at comparator falling edge
// - Forced turn-on after 150 us off
// - Ignore zero-current edges within 3.3 us
// - On-period ends when ramp meets error level
// - Error level clamped; below 1.0 V no switching
// - Reference stepped up over 5 ms
// - Proportional start, 30 ms handover to compensator
// - Run above 12 V until 8.5 V
// - Overvoltage stops gate, 0.175 V hysteresis
module crm_pfc_switch_sequencer
    import pfc_seq_pkg::*;
#(
    parameter logic [23:0] RESTART_CYCLES  = 24'(`RESTART_CYCLES),
    parameter logic [23:0] SOFT_CYCLES     = 24'(`SOFT_CYCLES),
    parameter logic [23:0] HANDOVER_CYCLES = 24'(`HANDOVER_CYCLES)
) (
    input  wire logic                 clock_i,
    input  wire logic                 resetn_i,
    input  wire logic                 vcc_above_start_i,
    input  wire logic                 vcc_below_stop_i,
    input  wire logic                 vcc_below_5v_i,
    input  wire logic                 vcc_above_2v_i,
    input  wire logic                 fb_above_ready_i,
    input  wire logic                 fb_below_release_i,
    input  wire logic                 fb_above_ovp_i,
    input  wire logic                 fb_below_ovp_release_i,
    input  wire logic                 zcs_above_high_i,
    input  wire logic                 zcs_below_low_i,
    input  wire logic                 comp_below_min_i,
    input  wire logic                 output_at_rated_i,
    input  wire logic [`RAMP_W-1:0]   comp_level_i,
    output var  logic                 gate_o,
    output var  logic                 ready_out_o,
    output var  logic                 ready_oe_o,
    output var  logic [`REF_W-1:0]    reference_step_o,
    output var  logic                 external_loop_o,
    output var  logic                 running_o
);
    logic zcs_cmp;
    logic zcs_cmp_d;
    logic next_zcs_cmp_d;
    logic ovp;
    logic ready_hyst;
    logic restart_done;
    logic blank_done;
    logic zcs_fall;
    sw_state_t  sw_state;
    sw_state_t  next_sw_state;
    ctl_state_t ctl_state;
    ctl_state_t next_ctl_state;
    logic                 run;
    logic                 next_run;
    logic                 started;
    logic                 next_started;
    logic [`RAMP_W-1:0]   ramp;
    logic [`RAMP_W-1:0]   next_ramp;
    logic [23:0]          ctl_count;
    logic [23:0]          next_ctl_count;
    logic [`REF_W-1:0]    next_reference_step;
    logic                 next_gate;
    logic                 next_ready;
    logic                 next_oe;
    logic                 next_external;
    logic                 turn_on;

    // Zero-current comparator with its own hysteresis
    hyst_flag u_zcs (
        .clock_i      (clock_i),
        .resetn_i     (resetn_i),
        .above_high_i (zcs_above_high_i),
        .below_low_i  (zcs_below_low_i),
        .flag_o       (zcs_cmp)
    );
    hyst_flag u_ovp (
        .clock_i      (clock_i),
        .resetn_i     (resetn_i),
        .above_high_i (fb_above_ovp_i),
        .below_low_i  (fb_below_ovp_release_i),
        .flag_o       (ovp)
    );
    hyst_flag u_ready (
        .clock_i      (clock_i),
        .resetn_i     (resetn_i),
        .above_high_i (fb_above_ready_i),
        .below_low_i  (fb_below_release_i),
        .flag_o       (ready_hyst)
    );
    interval_timer #(.COUNT(RESTART_CYCLES)) u_restart (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .start_i  (sw_state == ST_ON),
        .done_o   (restart_done)
    );
    // Armed from the first on cycle, not from next_gate, so no loop via turn_on
    interval_timer #(.COUNT(24'(`BLANK_CYCLES))) u_blank (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .start_i  ((sw_state == ST_ON) && (ramp == '0)),
        .done_o   (blank_done)
    );

    assign zcs_fall = zcs_cmp_d && !zcs_cmp;

    // Supply lockout and first-start memory
    always_comb begin
        next_run     = run;
        next_started = started;
        if (vcc_above_start_i) begin
            next_run     = 1'b1;
            next_started = 1'b1;
        end else if (vcc_below_stop_i) begin
            next_run = 1'b0;
        end
        if (vcc_below_5v_i) begin
            next_started = 1'b0;
        end
    end

    // Switching sequence; ramp stands in for the sawtooth
    always_comb begin
        next_sw_state  = sw_state;
        next_ramp      = ramp;
        next_zcs_cmp_d = zcs_cmp;
        turn_on        = 1'b0;
        case (sw_state)
            ST_IDLE: begin
                if (run && !ovp && !comp_below_min_i) begin
                    next_sw_state = ST_OFF;
                end
            end
            ST_ON: begin
                next_ramp = ramp + `RAMP_W'(1);
                // Clamped level at full scale gives the longest on-time
                if (ramp >= comp_level_i || ramp == {`RAMP_W{1'b1}}) begin
                    next_sw_state = ST_OFF;
                end
            end
            ST_OFF: begin
                next_ramp = '0;
                turn_on   = (zcs_fall && blank_done) || restart_done;
                if (turn_on) begin
                    next_sw_state = ST_ON;
                end
            end
            default: begin
                next_sw_state = ST_IDLE;
            end
        endcase
        // Stop wins over everything, gate drops at once
        if (!run || ovp || comp_below_min_i) begin
            next_sw_state = ST_IDLE;
            next_ramp     = '0;
        end
    end

    // Soft-start staircase and startup controller handover
    always_comb begin
        next_ctl_state      = ctl_state;
        next_ctl_count      = ctl_count;
        next_reference_step = reference_step_o;
        next_external       = external_loop_o;
        case (ctl_state)
            CT_OFF: begin
                next_reference_step = '0;
                next_external       = 1'b0;
                if (run) begin
                    next_ctl_state = CT_SOFT;
                    next_ctl_count = '0;
                end
            end
            CT_SOFT: begin
                // One step every SOFT_CYCLES/16, so the full ramp takes 5 ms
                next_ctl_count = ctl_count + 24'h000001;
                if (ctl_count >= (SOFT_CYCLES >> 4) - 24'h000001) begin
                    next_ctl_count = '0;
                    if (reference_step_o == {`REF_W{1'b1}}) begin
                        next_ctl_state = CT_PROP;
                    end else begin
                        next_reference_step = reference_step_o + `REF_W'(1);
                    end
                end
            end
            CT_PROP: begin
                if (output_at_rated_i) begin
                    next_ctl_state = CT_HANDOVER;
                    next_ctl_count = '0;
                end
            end
            CT_HANDOVER: begin
                next_ctl_count = ctl_count + 24'h000001;
                if (ctl_count >= HANDOVER_CYCLES - 24'h000001) begin
                    next_external = 1'b1;
                end
            end
            default: begin
                next_ctl_state = CT_OFF;
            end
        endcase
        if (!run) begin
            next_ctl_state = CT_OFF;
        end
    end

    // Outputs; ready pin drives low (oe high) only when not ready
    always_comb begin
        next_gate  = (next_sw_state == ST_ON);
        next_ready = started && ready_hyst && !vcc_below_5v_i;
        next_oe    = vcc_above_2v_i && !next_ready;
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sw_state         <= ST_IDLE;
            ctl_state        <= CT_OFF;
            run              <= 1'b0;
            started          <= 1'b0;
            ramp             <= '0;
            ctl_count        <= '0;
            zcs_cmp_d        <= 1'b0;
            gate_o           <= 1'b0;
            ready_out_o      <= 1'b0;
            ready_oe_o       <= 1'b0;
            reference_step_o <= '0;
            external_loop_o  <= 1'b0;
            running_o        <= 1'b0;
        end else begin
            sw_state         <= next_sw_state;
            ctl_state        <= next_ctl_state;
            run              <= next_run;
            started          <= next_started;
            ramp             <= next_ramp;
            ctl_count        <= next_ctl_count;
            zcs_cmp_d        <= next_zcs_cmp_d;
            gate_o           <= next_gate;
            ready_out_o      <= 1'b0;
            ready_oe_o       <= next_oe;
            reference_step_o <= next_reference_step;
            external_loop_o  <= next_external;
            running_o        <= next_run;
        end
    end

    sequence gate_rise_s;
        !gate_o ##1 gate_o;
    endsequence
    property stop_kills_gate_p;
        @(posedge clock_i) disable iff (!resetn_i)
        (!run || ovp || comp_below_min_i) |=> !gate_o;
    endproperty
    gate_stop_a: assert property (stop_kills_gate_p)
        else $error("gate high while stopped");
    ovp_gate_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        ovp |=> !gate_o)
        else $error("gate high during overvoltage");
    blank_hold_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        sw_state == ST_OFF && zcs_fall && !blank_done && !restart_done |=> !gate_o)
        else $error("zero-current edge taken inside blanking");
    blank_start_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        gate_rise_s |=> !blank_done)
        else $error("blanking not armed at gate rise");
    ready_low5v_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        vcc_below_5v_i && vcc_above_2v_i |=> ready_oe_o)
        else $error("ready not pulled low below 5 V");
    ready_float_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !vcc_above_2v_i |=> !ready_oe_o)
        else $error("ready driven below 2 V");
    ready_prestart_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !started && vcc_above_2v_i |=> ready_oe_o)
        else $error("ready released before start");
    ready_set_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        started && fb_above_ready_i && !vcc_below_5v_i && !vcc_above_start_i
        ##1 !vcc_below_5v_i |=> !ready_oe_o)
        else $error("ready not released above threshold");
    restart_turn_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        sw_state == ST_OFF && restart_done && run && !ovp && !comp_below_min_i
        |=> gate_o)
        else $error("restart timer did not turn gate on");
    ramp_end_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        sw_state == ST_ON && ramp >= comp_level_i |=> !gate_o)
        else $error("on-time did not end at ramp crossing");
    zcs_edge_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
        sw_state == ST_OFF && zcs_fall && blank_done && run && !ovp
        && !comp_below_min_i |=> gate_o)
        else $error("zero-current edge did not start on-period");
endmodule : crm_pfc_switch_sequencer
`default_nettype wire

// File: verilog/hyst_flag.sv
// Hysteresis flag from an upper and a lower comparator decision
`timescale 1ns/1ps
`default_nettype none
module hyst_flag (
    input  wire logic clock_i,
    input  wire logic resetn_i,
    input  wire logic above_high_i,
    input  wire logic below_low_i,
    output var  logic flag_o
);
    logic next_flag;
    always_comb begin
        next_flag = flag_o;
        if (above_high_i) begin
            next_flag = 1'b1;
        end else if (below_low_i) begin
            next_flag = 1'b0;
        end
    end
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_o <= 1'b0;
        end else begin
            flag_o <= next_flag;
        end
    end
endmodule : hyst_flag
`default_nettype wire

// File: verilog/interval_timer.sv
// Restartable down counter that flags when its interval has elapsed
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
    parameter logic [23:0] COUNT = 24'h000001
) (
    input  wire logic clock_i,
    input  wire logic resetn_i,
    input  wire logic start_i,
    output var  logic done_o
);
    logic [23:0] count;
    logic [23:0] next_count;
    always_comb begin
        next_count = count;
        if (start_i) begin
            next_count = COUNT;
        end else if (count != 24'h000000) begin
            next_count = count - 24'h000001;
        end
    end
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count <= 24'h000000;
        end else begin
            count <= next_count;
        end
    end
    assign done_o = (count == 24'h000000) && !start_i;
endmodule : interval_timer
`default_nettype wire

// File: verilog/pfc_seq_cfg.svh
// Timing counts and field constants for the switching sequencer
`ifndef PFC_SEQ_CFG_SVH
`define PFC_SEQ_CFG_SVH
`define CLK_PERIOD_NS      10
`define RESTART_TIME_NS    150000
`define RESTART_CYCLES     (`RESTART_TIME_NS / `CLK_PERIOD_NS)
`define BLANK_TIME_NS      3300
`define BLANK_CYCLES       (`BLANK_TIME_NS / `CLK_PERIOD_NS)
`define SOFT_TIME_MS       5
`define SOFT_CYCLES        (`SOFT_TIME_MS * 100000)
`define HANDOVER_TIME_MS   30
`define HANDOVER_CYCLES    (`HANDOVER_TIME_MS * 100000)
`define SOFT_STEPS         16
`define REF_W              4
`define RAMP_W             8
`define TIMER_W            24
`endif

// File: verilog/pfc_seq_pkg.sv
// Types shared by the switching sequencer
package pfc_seq_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ON,
        ST_OFF
    } sw_state_t;
    typedef enum logic [1:0] {
        CT_OFF,
        CT_SOFT,
        CT_PROP,
        CT_HANDOVER
    } ctl_state_t;
endpackage : pfc_seq_pkg
